/* alu_ops_pkg.sv */
package alu_ops_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [31:0] CMD_OFFSET       = 32'h0000_0000;
  localparam logic [31:0] ACC_OFFSET       = 32'h0000_0004;
  localparam logic [31:0] STATUS_OFFSET    = 32'h0000_0008;
  localparam logic [31:0] WATCHDOG_OFFSET  = 32'h0000_000c;
  localparam logic [31:0] FILE_BASE_OFFSET = 32'h0000_0200;
  localparam logic [21:0] ADDR_HIGH_ZERO   = 22'h00_0000;
  localparam int          FILE_SEL_BIT     = 9;
  localparam int          FILE_DEPTH       = 128;
  localparam logic [6:0]  FILE_ADDR_MAX    = 7'h7f;

  // ***************************************************************
  // Reset and wrap values
  // ***************************************************************
  localparam logic [7:0]  ACC_RESET        = 8'h00;
  localparam logic [7:0]  FILE_RESET       = 8'h00;
  localparam logic [7:0]  WATCHDOG_CLEARED = 8'h00;
  localparam logic [7:0]  PRESCALE_CLEARED = 8'h00;
  localparam logic [7:0]  PRESCALE_LAST    = 8'hff;
  localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

  // ***************************************************************
  // AHB-Lite codes
  // ***************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
  localparam logic        HRESP_OKAY       = 1'b0;

  // ***************************************************************
  // Operations
  // ***************************************************************
  typedef enum logic [3:0] {
    no_op                   = 4'h0,
    rotate_right_carry_op   = 4'h1,
    rotate_left_carry_op    = 4'h2,
    sleep_op                = 4'h3,
    literal_minus_acc_op    = 4'h4,
    file_minus_acc_op       = 4'h5,
    subtract_with_borrow_op = 4'h6,
    nibble_exchange_op      = 4'h7
  } op_e;

  // Command word: op [3:0], dest [4], file address [11:5], literal [19:12]
  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] faddr;
    logic       dest;
    logic [3:0] op;
  } cmd_s;

  // Status word: carry [0], digit carry [1], zero [2], timeout [3], powerdown [4], sleeping [5]
  typedef struct packed {
    logic sleeping;
    logic powerdown_status_bit;
    logic timeout_status_bit;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } status_s;

  localparam status_s STATUS_RESET = 6'h18;

endpackage

/* alu_ops_top.sv */
`timescale 1ns/100ps

// Function
// [RULE1] Rotate right: bit0 to carry, carry to bit7
// [RULE2] Destination bit selects accumulator or file register
// [RULE3] Rotate left: bit7 to carry, carry to bit0
// [RULE4] Sleep clears watchdog counter and prescaler
// [RULE5] Sleep clears powerdown bit, sets timeout bit
// [RULE6] Literal minus accumulator goes to accumulator
// [RULE7] Literal subtract carry and digit-carry from compare
// [RULE8] File minus accumulator routed by destination
// [RULE9] File subtract carry and digit-carry from compare
// [RULE10] File minus accumulator minus inverted carry
// [RULE11] Swap nibbles, flags untouched
// [RULE12] Subtracts set zero on zero result
module alu_ops_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             sleeping
);

  // ***************************************************************
  // State
  // ***************************************************************
  // Core registers seen by software
  logic [7:0]            acc_reg;
  logic [7:0]            file_mem [alu_ops_pkg::FILE_DEPTH];
  alu_ops_pkg::status_s  status_reg;
  alu_ops_pkg::cmd_s     cmd_reg;
  // Watchdog stages, both cleared by sleep
  logic [7:0]            watchdog_counter_reg;
  logic [7:0]            prescale_reg;

  // Bus data phase tracking
  logic [31:0]           addr_reg;
  logic                  write_phase_reg;
  logic                  read_phase_reg;
  logic                  read_wait_reg;
  logic [31:0]           hrdata_reg;

  // ***************************************************************
  // Subtractor: a - b - borrow_in, returns {carry, digit carry, result}
  // ***************************************************************
  // Nine and five bit chains expose the borrow out of bit 7 and bit 3;
  // carry and digit carry are that borrow inverted
  function automatic logic [9:0] subtract(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       borrow_in
  );
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
    subtract = {~full[8], ~low[4], full[7:0]};
  endfunction

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  // Only whole-word NONSEQ transfers start a data phase
  wire       addr_take   = hsel & hready
                         & (htrans == alu_ops_pkg::HTRANS_NONSEQ)
                         & (hsize == alu_ops_pkg::HSIZE_WORD);

  // Register hits on the address held for the data phase
  wire       high_zero   = (addr_reg[31:10] == alu_ops_pkg::ADDR_HIGH_ZERO);
  wire       hit_cmd     = (addr_reg == alu_ops_pkg::CMD_OFFSET);
  wire       hit_acc     = (addr_reg == alu_ops_pkg::ACC_OFFSET);
  wire       hit_status  = (addr_reg == alu_ops_pkg::STATUS_OFFSET);
  wire       hit_wdog    = (addr_reg == alu_ops_pkg::WATCHDOG_OFFSET);
  wire       hit_file    = high_zero & addr_reg[alu_ops_pkg::FILE_SEL_BIT] & (addr_reg[1:0] == 2'h0);
  wire [6:0] bus_faddr   = addr_reg[8:2];

  // Write strobes, live in the single data phase cycle of a write
  wire       wr_cmd      = write_phase_reg & hit_cmd;
  wire       wr_acc      = write_phase_reg & hit_acc;
  wire       wr_status   = write_phase_reg & hit_status;
  wire       wr_file     = write_phase_reg & hit_file;

  // ***************************************************************
  // Bus response
  // ***************************************************************
  // Reads take one wait state so the data comes from a flip-flop;
  // writes never stall, so a read right after a write sees the new value
  assign hreadyout = ~(read_phase_reg & ~read_wait_reg);
  assign hresp     = alu_ops_pkg::HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  // Sleep state straight from its status flop
  assign sleeping  = status_reg.sleeping;

  // ***************************************************************
  // Command execution
  // ***************************************************************
  // Command word as it stands on hwdata in the write data phase
  alu_ops_pkg::cmd_s     cmd_in;
  alu_ops_pkg::op_e      op_in;
  logic [7:0]            operand;

  // Decode outputs
  logic [7:0]            result;
  logic [9:0]            sub_out;
  logic                  result_valid;
  logic                  result_to_acc;
  logic                  flags_sub;
  logic                  carry_only;
  logic                  do_sleep;

  assign cmd_in  = alu_ops_pkg::cmd_s'(hwdata[19:0]);
  assign op_in   = alu_ops_pkg::op_e'(cmd_in.op);
  assign operand = file_mem[cmd_in.faddr];

  // ***************************************************************
  // Candidate results
  // ***************************************************************
  // Rotates pass one bit through carry, swap exchanges the nibbles
  wire [7:0] rot_right_res = {status_reg.carry_flag, operand[7:1]};  // [RULE1]
  wire [7:0] rot_left_res  = {operand[6:0], status_reg.carry_flag};  // [RULE3]
  wire [7:0] swap_res      = {operand[3:0], operand[7:4]};  // [RULE11]
  wire       rot_carry_out = (op_in == alu_ops_pkg::rotate_right_carry_op) ? operand[0] : operand[7];

  // All three subtracts run every cycle; the decode picks one
  wire       borrow_bit    = ~status_reg.carry_flag;  // [RULE10]
  wire [9:0] lit_sub       = subtract(cmd_in.literal, acc_reg, 1'b0);  // [RULE6]
  wire [9:0] file_sub      = subtract(operand, acc_reg, 1'b0);  // [RULE8]
  wire [9:0] borrow_sub    = subtract(operand, acc_reg, borrow_bit);  // [RULE10]

  // Operation select and flag routing;
  // sleep and the no-op codes produce no result
  always_comb begin
    // Defaults: operand as result, routed by the destination bit, nothing executes
    result        = operand;
    sub_out       = 10'h000;
    result_valid  = 1'b0;
    result_to_acc = ~cmd_in.dest;
    flags_sub     = 1'b0;
    carry_only    = 1'b0;
    do_sleep      = 1'b0;
    case (op_in)
      alu_ops_pkg::rotate_right_carry_op: begin
        result       = rot_right_res;  // [RULE1]
        result_valid = 1'b1;
        carry_only   = 1'b1;
      end
      alu_ops_pkg::rotate_left_carry_op: begin
        result       = rot_left_res;  // [RULE3]
        result_valid = 1'b1;
        carry_only   = 1'b1;
      end
      alu_ops_pkg::sleep_op: begin
        // Sleep has no data result, only status and watchdog effects
        do_sleep = 1'b1;
      end
      alu_ops_pkg::literal_minus_acc_op: begin
        sub_out       = lit_sub;  // [RULE6]
        result        = sub_out[7:0];
        result_valid  = 1'b1;
        result_to_acc = 1'b1;  // [RULE6]
        flags_sub     = 1'b1;  // [RULE7]
      end
      alu_ops_pkg::file_minus_acc_op: begin
        sub_out      = file_sub;  // [RULE8]
        result       = sub_out[7:0];
        result_valid = 1'b1;
        flags_sub    = 1'b1;  // [RULE9]
      end
      alu_ops_pkg::subtract_with_borrow_op: begin
        sub_out      = borrow_sub;  // [RULE10]
        result       = sub_out[7:0];
        result_valid = 1'b1;
        flags_sub    = 1'b1;  // [RULE10]
      end
      alu_ops_pkg::nibble_exchange_op: begin
        result       = swap_res;  // [RULE11]
        result_valid = 1'b1;
      end
      default: begin
        result_valid = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // Execute strobes
  // ***************************************************************
  // A command executes at the edge that ends its write data phase
  wire exec      = wr_cmd;
  wire exec_acc  = exec & result_valid & result_to_acc;  // [RULE2]
  wire exec_file = exec & result_valid & ~result_to_acc;  // [RULE2]
  wire exec_flag = exec & flags_sub;
  wire exec_rot  = exec & carry_only;
  wire exec_slp  = exec & do_sleep;

  // Flag values presented at the execute edge
  wire carry_exec = flags_sub ? sub_out[9] : rot_carry_out;  // [RULE7] [RULE9]
  wire dc_exec    = sub_out[8];  // [RULE7] [RULE9]
  wire zero_exec  = (sub_out[7:0] == 8'h00);  // [RULE12]

  // Prescaler wraps into the watchdog counter
  wire prescale_wrap = (prescale_reg == alu_ops_pkg::PRESCALE_LAST);

  // ***************************************************************
  // Bus address phase capture
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg        <= alu_ops_pkg::READ_ZERO;
      write_phase_reg <= 1'b0;
      read_phase_reg  <= 1'b0;
      read_wait_reg   <= 1'b0;
    end else if (hreadyout) begin
      // A stalled read keeps its address until the data is out
      addr_reg        <= haddr;
      write_phase_reg <= addr_take & hwrite;
      read_phase_reg  <= addr_take & ~hwrite;
      read_wait_reg   <= 1'b0;
    end else begin
      read_wait_reg   <= 1'b1;
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  // Read data mux, unmapped reads give zero
  logic [31:0] read_mux;
  assign read_mux = hit_cmd    ? {12'h000, cmd_reg} :
                    hit_acc    ? {24'h00_0000, acc_reg} :
                    hit_status ? {26'h000_0000, status_reg} :
                    hit_wdog   ? {16'h0000, prescale_reg, watchdog_counter_reg} :
                    hit_file   ? {24'h00_0000, file_mem[bus_faddr]} :
                                 alu_ops_pkg::READ_ZERO;

  // Read data register loaded in the wait cycle;
  // it then holds until the next read so hrdata never glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= alu_ops_pkg::READ_ZERO;
    end else if (read_phase_reg & ~read_wait_reg) begin
      hrdata_reg <= read_mux;
    end
  end

  // ***************************************************************
  // Accumulator and command register
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= alu_ops_pkg::ACC_RESET;
      cmd_reg <= '0;
    end else begin
      // A bus write and a command never share a data phase
      if (wr_acc) begin
        acc_reg <= hwdata[7:0];
      end else if (exec_acc) begin
        acc_reg <= result;  // [RULE2]
      end
      if (wr_cmd) begin
        // Last command kept for read back
        cmd_reg <= cmd_in;
      end
    end
  end

  // ***************************************************************
  // File register array
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < alu_ops_pkg::FILE_DEPTH; i++) begin
        file_mem[i] <= alu_ops_pkg::FILE_RESET;
      end
    end else if (wr_file) begin
      // Software writes by bus address, commands by file address
      file_mem[bus_faddr] <= hwdata[7:0];
    end else if (exec_file) begin
      file_mem[cmd_in.faddr] <= result;  // [RULE2]
    end
  end

  // ***************************************************************
  // Status flags
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= alu_ops_pkg::STATUS_RESET;
    end else if (wr_status) begin
      status_reg.carry_flag       <= hwdata[0];
      status_reg.digit_carry_flag <= hwdata[1];
      status_reg.zero_flag        <= hwdata[2];
    end else if (exec) begin
      // Subtracts update three flags, rotates only the carry
      if (exec_flag) begin
        status_reg.carry_flag       <= carry_exec;  // [RULE7] [RULE9]
        status_reg.digit_carry_flag <= dc_exec;  // [RULE7] [RULE9]
        status_reg.zero_flag        <= zero_exec;  // [RULE12]
      end
      if (exec_rot) begin
        status_reg.carry_flag       <= carry_exec;  // [RULE1] [RULE3]
      end
      // Sleep touches the timeout and powerdown bits here, and the sleeping bit below
      if (exec_slp) begin
        status_reg.powerdown_status_bit <= 1'b0;  // [RULE5]
        status_reg.timeout_status_bit   <= 1'b1;  // [RULE5]
      end
      // Any command other than sleep wakes the core
      status_reg.sleeping <= do_sleep;
    end
  end

  // ***************************************************************
  // Watchdog counter and prescaler
  // ***************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_reg         <= alu_ops_pkg::PRESCALE_CLEARED;
      watchdog_counter_reg <= alu_ops_pkg::WATCHDOG_CLEARED;
    end else if (exec_slp) begin
      // Both stages restart from zero at the sleep execute edge
      prescale_reg         <= alu_ops_pkg::PRESCALE_CLEARED;  // [RULE4]
      watchdog_counter_reg <= alu_ops_pkg::WATCHDOG_CLEARED;  // [RULE4]
    end else begin
      // Prescaler free runs; the counter steps on its wrap
      prescale_reg <= prescale_reg + 8'h01;
      if (prescale_wrap) begin
        watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
      end
    end
  end

endmodule

/* alu_ops_sva.sv */
`timescale 1ns/100ps
module alu_ops_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        sleeping
);
  // ****
  // Phase tracking
  // ****
  logic rd_ph;
  logic cmd_ph;
  wire  go = hsel & hready & hreadyout & (htrans == alu_ops_pkg::HTRANS_NONSEQ) & (hsize == alu_ops_pkg::HSIZE_WORD);
  wire  sleep_cmd = cmd_ph & (hwdata[3:0] == 4'h3);

  // Marks the data phase of a read and of a command write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph  <= 1'b0;
      cmd_ph <= 1'b0;
    end else begin
      rd_ph  <= go & ~hwrite;
      cmd_ph <= go & hwrite & (haddr == alu_ops_pkg::CMD_OFFSET);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****
  // Properties
  // ****
  chk_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_write_ready: assert property (go && hwrite |=> hreadyout) else $error("write data phase stalled");
  chk_ready_high: assert property (!rd_ph |-> hreadyout) else $error("hreadyout low outside read");
  chk_resp_okay: assert property (hresp == alu_ops_pkg::HRESP_OKAY) else $error("response not okay");
  chk_sleep_enter: assert property (sleep_cmd |=> sleeping) else $error("sleep not entered");
  chk_sleep_leave: assert property (cmd_ph && !sleep_cmd |=> !sleeping) else $error("sleep not left");
  chk_sleep_hold: assert property (!cmd_ph |=> $stable(sleeping)) else $error("sleeping moved alone");
  chk_rdata_hold: assert property (!rd_ph |=> $stable(hrdata)) else $error("hrdata moved without read");
endmodule

bind alu_ops_top alu_ops_sva i_alu_ops_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .sleeping(sleeping)
);

/* tb.sv */
`timescale 1ns/100ps
module tb;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = alu_ops_pkg::HSIZE_WORD;
  logic [31:0] hwdata  = 32'h0;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         sleeping;
  logic [31:0] q;
  logic [10:0] e;
  logic [3:0]  op;
  int          error_cnt   = 0;
  int          check_count = 0;
  logic [7:0]  opa [4] = '{8'h05, 8'h10, 8'h00, 8'hff};
  logic [7:0]  opb [4] = '{8'h05, 8'h01, 8'h01, 8'h00};
  localparam logic [31:0] ACC = alu_ops_pkg::ACC_OFFSET;
  localparam logic [31:0] STA = alu_ops_pkg::STATUS_OFFSET;

  alu_ops_top i_alu_ops_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sleeping(sleeping)
  );

  // Clock of 50 ns
  initial begin
    forever #25 hclk = ~hclk;
  end

  // ****
  // Bus tasks
  // ****
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= alu_ops_pkg::HTRANS_NONSEQ;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic check(input logic [31:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    cmp(q, x);
  endtask

  task automatic cmd(input logic [3:0] o, input logic d, input logic [6:0] f, input logic [7:0] k);
    bus(1'b1, alu_ops_pkg::CMD_OFFSET, {12'h0, k, f, d, o});
  endtask

  function automatic logic [31:0] fa(input logic [6:0] f);
    return alu_ops_pkg::FILE_BASE_OFFSET + {23'h0, f, 2'b00};
  endfunction

  // Expected {zero, digit carry, carry, result}: carry and digit carry set when what is taken away does not exceed a
  function automatic logic [10:0] sub_exp(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] need;
    logic [4:0] need_lo;
    logic [7:0] res;
    need    = {1'b0, b} + {8'h00, ~c};
    need_lo = {1'b0, b[3:0]} + {4'h0, ~c};
    res     = a - b - {7'h00, ~c};
    return {res == 8'h00, need_lo <= {1'b0, a[3:0]}, need <= {1'b0, a}, res};
  endfunction

  // Rotate or swap with zero flag preset, other destination must keep its value
  task automatic rot(input logic [3:0] o, input logic d, input logic [6:0] f, input logic [7:0] v,
                     input logic c, input logic [7:0] r, input logic co);
    bus(1'b1, fa(f), {24'h0, v});
    bus(1'b1, ACC, 32'h3c);
    bus(1'b1, STA, {30'h1, 1'b1, c});
    cmd(o, d, f, 8'h0);
    check(fa(f), {24'h0, d ? r : v});
    check(ACC, {24'h0, d ? 8'h3c : r});
    check(STA, {30'h7, 1'b1, co});
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    summarize();
  end

  // ****
  // Tests
  // ****
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(ACC, 32'h0);
    check(STA, 32'h18);
    check(fa(7'h7f), 32'h0);
    bus(1'b1, 32'h100, 32'h55);
    check(32'h100, 32'h0);
    hsize <= 3'h0;
    bus(1'b1, ACC, 32'h77);
    hsize <= alu_ops_pkg::HSIZE_WORD;
    check(ACC, 32'h0);
    $display("reset test done");
    rot(alu_ops_pkg::rotate_right_carry_op, 1'b1, 7'h05, 8'he7, 1'b0, 8'h73, 1'b1);
    rot(alu_ops_pkg::rotate_right_carry_op, 1'b0, 7'h7f, 8'h02, 1'b1, 8'h81, 1'b0);
    rot(alu_ops_pkg::rotate_left_carry_op, 1'b0, 7'h01, 8'he6, 1'b0, 8'hcc, 1'b1);
    rot(alu_ops_pkg::rotate_left_carry_op, 1'b1, 7'h00, 8'h81, 1'b1, 8'h03, 1'b1);
    rot(alu_ops_pkg::nibble_exchange_op, 1'b1, 7'h02, 8'ha5, 1'b1, 8'h5a, 1'b1);
    rot(alu_ops_pkg::nibble_exchange_op, 1'b0, 7'h03, 8'h0f, 1'b0, 8'hf0, 1'b0);
    $display("shift test done");
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        op = 4'h4 + 4'(j);
        bus(1'b1, STA, {31'h0, i[0]});
        bus(1'b1, ACC, {24'h0, opb[i]});
        bus(1'b1, fa(7'h09), {24'h0, opa[i]});
        cmd(op, i[1], 7'h09, opa[i]);
        e = sub_exp(opa[i], opb[i], (op == 4'h6) ? i[0] : 1'b1);
        check((i[1] && op != 4'h4) ? fa(7'h09) : ACC, {24'h0, e[7:0]});
        check(STA, {29'h3, e[10:8]});
      end
    end
    $display("subtract test done");
    bus(1'b0, alu_ops_pkg::WATCHDOG_OFFSET, 32'h0);
    cmp({31'h0, (q[15:0] != 16'h0000)}, 32'h1);
    bus(1'b1, STA, 32'h5);
    cmd(alu_ops_pkg::sleep_op, 1'b0, 7'h0, 8'h0);
    @(posedge hclk);
    cmp({31'h0, sleeping}, 32'h1);
    bus(1'b0, alu_ops_pkg::WATCHDOG_OFFSET, 32'h0);
    cmp(q & 32'hffff_f8ff, 32'h0);
    check(STA, 32'h2d);
    cmd(alu_ops_pkg::no_op, 1'b0, 7'h0, 8'h0);
    @(posedge hclk);
    cmp({31'h0, sleeping}, 32'h0);
    check(STA, 32'h0d);
    $display("sleep test done");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(STA, 32'h18);
    check(ACC, 32'h0);
    $display("second reset test done");
    summarize();
  end
endmodule
